// file: design/endpoint_descriptor_block.sv
// Purpose: six endpoint descriptors behind apb, with a buffer manager port
// Assumes: apb and buffer manager on pclk; completion pulses last one cycle
// Notes:   pready follows one cycle into the access phase
`timescale 1ns/1ns
`default_nettype none

module endpoint_descriptor_block
	import endpoint_descriptor_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire ep_sel_t bm_query,
	output bm_view_t bm_view,
	input wire bm_done_t bm_done,
	output logic irq
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	// shared store
	logic [7:0] desc_mem [SLOTS*DESC_BYTES];      // descriptor bytes
	logic [SLOTS-1:0] stall_reg;                  // stall bits, reset clear
	logic [SLOTS-1:0] irq_status_reg;             // sticky completion flags
	logic [SLOTS-1:0] irq_mask_reg;               // interrupt enables
	logic pready_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic irq_reg;
	bm_view_t view_reg;

	// ----------------------------------------------------------------
	// local decode constants
	// ----------------------------------------------------------------
	// low index bits that pick the entry inside a descriptor
	localparam logic [IDX_W-1:0] ENTRY_MASK = IDX_W'(DESC_BYTES - 1);
	// single set bit, shifted to a field position
	localparam logic [7:0] BIT_ONE = 8'h01;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	logic [IDX_W-1:0] idx;                         // register index
	logic in_desc;                                 // index falls in a descriptor
	logic [2:0] slot;                              // descriptor number 0..5
	logic [2:0] ofs;                               // entry within descriptor
	logic is_status;
	logic is_mask;
	logic mapped;
	logic wr_fire;                                 // write completes this edge
	logic rd_fire;

	assign idx = paddr[IDX_W+1:2];
	assign ofs = idx[2:0];

	// decode descriptor windows and own registers
	always_comb begin
		in_desc = 1'b0;
		slot = 3'd0;
		is_status = 1'b0;
		is_mask = 1'b0;
		if (paddr[ADDR_W-1:IDX_W+2] != '0 || paddr[1:0] != 2'b00) begin
			in_desc = 1'b0;
		end else if ((idx & ~ENTRY_MASK) == OUT_EP1_IDX) begin
			in_desc = 1'b1;
			slot = 3'd0;
		end else if ((idx & ~ENTRY_MASK) == OUT_EP2_IDX) begin
			in_desc = 1'b1;
			slot = 3'd1;
		end else if ((idx & ~ENTRY_MASK) == OUT_EP3_IDX) begin
			in_desc = 1'b1;
			slot = 3'd2;
		end else if ((idx & ~ENTRY_MASK) == IN_EP1_IDX) begin
			in_desc = 1'b1;
			slot = 3'd3;
		end else if ((idx & ~ENTRY_MASK) == IN_EP2_IDX) begin
			in_desc = 1'b1;
			slot = 3'd4;
		end else if ((idx & ~ENTRY_MASK) == IN_EP3_IDX) begin
			in_desc = 1'b1;
			slot = 3'd5;
		end else if (idx == IRQ_STATUS_IDX) begin
			is_status = 1'b1;
		end else if (idx == IRQ_MASK_IDX) begin
			is_mask = 1'b1;
		end
	end

	assign mapped = in_desc | is_status | is_mask;
	assign wr_fire = psel & penable & pready_reg & pwrite & mapped;
	assign rd_fire = psel & penable & ~pready_reg & ~pwrite;

	// slot number of an endpoint reference
	function automatic logic [2:0] slot_of(input logic in_dir, input logic [1:0] ep);
		slot_of = 3'(ep - 2'd1) + (in_dir ? 3'(EP_PER_DIR) : 3'd0);
	endfunction

	// byte address inside the store
	function automatic logic [5:0] byte_of(input logic [2:0] s, input logic [2:0] o);
		byte_of = {s, o};
	endfunction

	// completion reference is real and endpoint may be used
	logic done_ok;
	logic [2:0] done_slot;
	assign done_slot = slot_of(bm_done.in_dir, bm_done.ep);
	assign done_ok = bm_done.valid && bm_done.ep != 2'd0 &&
		desc_mem[byte_of(done_slot, OFS_CONFIG)][CFG_ENABLE_BIT];

	// ----------------------------------------------------------------
	// apb handshake
	// ----------------------------------------------------------------
	// pready rises one cycle into the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= psel & penable & ~pready_reg;
			pslverr_reg <= psel & penable & ~pready_reg & ~mapped;
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	// sampled before pready, so it stands at the completing edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= '0;
		end else if (rd_fire) begin
			prdata_reg <= '0;
			if (in_desc) begin
				if (ofs == OFS_CONFIG) begin
					prdata_reg[7:0] <= (desc_mem[byte_of(slot, ofs)] & CFG_RSV_MASK &
						~(BIT_ONE << CFG_STALL_BIT)) | (8'(stall_reg[slot]) << CFG_STALL_BIT);
				end else if (ofs == OFS_SPARE_A || ofs == OFS_SPARE_B) begin
					prdata_reg[7:0] <= BYTE_RESET;
				end else begin
					prdata_reg[7:0] <= desc_mem[byte_of(slot, ofs)];
				end
			end else if (is_status) begin
				prdata_reg[SLOTS-1:0] <= irq_status_reg;
			end else if (is_mask) begin
				prdata_reg[SLOTS-1:0] <= irq_mask_reg;
			end
		end
	end

	// ----------------------------------------------------------------
	// descriptor store
	// ----------------------------------------------------------------
	// firmware writes; hardware updates count and toggle on completion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < SLOTS*DESC_BYTES; i++) begin
				desc_mem[i] <= BYTE_RESET;
			end
		end else begin
			if (wr_fire && in_desc && ofs != OFS_SPARE_A && ofs != OFS_SPARE_B) begin
				desc_mem[byte_of(slot, ofs)] <= pwdata[7:0];
			end
			if (done_ok) begin
				if (bm_done.use_y) begin
					desc_mem[byte_of(done_slot, OFS_Y_COUNT)] <= bm_done.count;
				end else begin
					desc_mem[byte_of(done_slot, OFS_X_COUNT)] <= bm_done.count;
				end
				desc_mem[byte_of(done_slot, OFS_CONFIG)][CFG_TOGGLE_BIT] <=
					~desc_mem[byte_of(done_slot, OFS_CONFIG)][CFG_TOGGLE_BIT];
				// base entries are not touched here
			end
		end
	end

	// ----------------------------------------------------------------
	// stall bits
	// ----------------------------------------------------------------
	// stall clears at reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stall_reg <= '0;
		end else if (wr_fire && in_desc && ofs == OFS_CONFIG) begin
			stall_reg[slot] <= pwdata[CFG_STALL_BIT];
		end
	end

	// ----------------------------------------------------------------
	// interrupt registers
	// ----------------------------------------------------------------
	// mask register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_reg <= '0;
		end else if (wr_fire && is_mask) begin
			irq_mask_reg <= pwdata[SLOTS-1:0];
		end
	end

	// sticky status, write one clears, a new event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_reg <= '0;
		end else begin
			for (int i = 0; i < SLOTS; i++) begin
				if (done_ok && done_slot == 3'(i) &&
					desc_mem[byte_of(done_slot, OFS_CONFIG)][CFG_IRQ_EN_BIT]) begin
					irq_status_reg[i] <= 1'b1;
				end else if (wr_fire && is_status && pwdata[i]) begin
					irq_status_reg[i] <= 1'b0;
				end
			end
		end
	end

	// level interrupt from unmasked status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(irq_status_reg & irq_mask_reg);
		end
	end

	// ----------------------------------------------------------------
	// buffer manager view
	// ----------------------------------------------------------------
	logic [2:0] q_slot;
	logic [7:0] q_cfg;
	assign q_slot = slot_of(bm_query.in_dir, bm_query.ep);
	assign q_cfg = desc_mem[byte_of(q_slot, OFS_CONFIG)];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			view_reg <= '0;
		end else if (bm_query.valid && bm_query.ep != 2'd0) begin
			view_reg.valid <= 1'b1;
			view_reg.enabled <= q_cfg[CFG_ENABLE_BIT];
			view_reg.stall <= stall_reg[q_slot];
			view_reg.double_buffer_enable <= q_cfg[CFG_DOUBLE_BUFFER_ENABLE_BIT];
			view_reg.toggle <= q_cfg[CFG_TOGGLE_BIT];
			view_reg.x_addr <= {desc_mem[byte_of(q_slot, OFS_X_BASE)], BASE_PAD'(0)};
			view_reg.y_addr <= {desc_mem[byte_of(q_slot, OFS_Y_BASE)], BASE_PAD'(0)};
			view_reg.x_count <= desc_mem[byte_of(q_slot, OFS_X_COUNT)];
			view_reg.y_count <= desc_mem[byte_of(q_slot, OFS_Y_COUNT)];
			view_reg.size <= desc_mem[byte_of(q_slot, OFS_SIZE)][6:0];
		end else begin
			view_reg.valid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq = irq_reg;
	assign bm_view = view_reg;

endmodule : endpoint_descriptor_block

`default_nettype wire

// file: pkg/endpoint_descriptor_pkg.sv
// Purpose: shared constants and carriers for the endpoint descriptor block
// Assumes: 32-bit apb data, one register per aligned word
// Notes:   descriptor indices follow the low byte of the descriptor memory address
package endpoint_descriptor_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int EP_PER_DIR = 3;                 // endpoints 1..3 per direction
	localparam int SLOTS = 2 * EP_PER_DIR;         // six descriptors
	localparam int DESC_BYTES = 8;                 // bytes per descriptor
	localparam int IDX_W = 7;                      // register index width
	localparam int ADDR_W = 12;                    // apb byte address width

	// ----------------------------------------------------------------
	// descriptor entry offsets (register index within a descriptor)
	// ----------------------------------------------------------------
	localparam logic [2:0] OFS_CONFIG = 3'h0;
	localparam logic [2:0] OFS_X_BASE = 3'h1;
	localparam logic [2:0] OFS_X_COUNT = 3'h2;
	localparam logic [2:0] OFS_SPARE_A = 3'h3;
	localparam logic [2:0] OFS_SPARE_B = 3'h4;
	localparam logic [2:0] OFS_Y_BASE = 3'h5;
	localparam logic [2:0] OFS_Y_COUNT = 3'h6;
	localparam logic [2:0] OFS_SIZE = 3'h7;

	// ----------------------------------------------------------------
	// descriptor base indices (low byte of memory address ff08h...)
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] OUT_EP1_IDX = 7'h08;
	localparam logic [IDX_W-1:0] OUT_EP2_IDX = 7'h10;
	localparam logic [IDX_W-1:0] OUT_EP3_IDX = 7'h18;
	localparam logic [IDX_W-1:0] IN_EP1_IDX = 7'h48;
	localparam logic [IDX_W-1:0] IN_EP2_IDX = 7'h50;
	localparam logic [IDX_W-1:0] IN_EP3_IDX = 7'h58;
	localparam int IN_DIR_BIT = 6;                 // index bit that selects input side

	// interrupt registers
	localparam logic [IDX_W-1:0] IRQ_STATUS_IDX = 7'h70;
	localparam logic [IDX_W-1:0] IRQ_MASK_IDX = 7'h71;

	// ----------------------------------------------------------------
	// configuration byte fields
	// ----------------------------------------------------------------
	localparam int CFG_IRQ_EN_BIT = 2;             // completion_irq_enable
	localparam int CFG_STALL_BIT = 3;              // stall
	localparam int CFG_DOUBLE_BUFFER_ENABLE_BIT = 4;               // double_buffer_enable
	localparam int CFG_TOGGLE_BIT = 5;             // data_toggle
	localparam int CFG_ISO_BIT = 6;                // must stay 0
	localparam int CFG_ENABLE_BIT = 7;             // manager_enable
	localparam logic [7:0] CFG_RSV_MASK = 8'hFC;   // bits 1..0 read zero
	localparam int NAK_BIT = 7;                    // byte count full flag
	localparam int BASE_PAD = 3;                   // zero low bits of buffer address
	localparam int BUF_ADDR_W = 11;                // buffer address width
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic in_dir;            // 1 = input endpoint
		logic [1:0] ep;          // 1..3
	} ep_sel_t;

	typedef struct packed {
		logic valid;
		logic in_dir;
		logic [1:0] ep;
		logic use_y;             // which buffer finished
		logic [7:0] count;       // new byte count entry, nak flag included
	} bm_done_t;

	typedef struct packed {
		logic valid;             // endpoint selected exists
		logic enabled;           // manager may service it
		logic stall;
		logic double_buffer_enable;
		logic toggle;
		logic [BUF_ADDR_W-1:0] x_addr;
		logic [BUF_ADDR_W-1:0] y_addr;
		logic [7:0] x_count;
		logic [7:0] y_count;
		logic [6:0] size;
	} bm_view_t;

endpackage : endpoint_descriptor_pkg

// file: bench/endpoint_descriptor_monitor.sv
// Purpose: port checks of the descriptor block
// Assumes: one clock, async active-low reset
// Notes:   bound from the testbench
`timescale 1ns/1ns
`default_nettype none
module endpoint_descriptor_monitor
	import endpoint_descriptor_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire ep_sel_t bm_query,
	input wire bm_view_t bm_view,
	input wire bm_done_t bm_done,
	input wire logic irq
);
	// --------
	// decode
	// --------
	logic [6:0] idx; // register index
	logic in_desc, mapped, zero_rd, q_ok;
	assign idx = paddr[8:2];
	assign in_desc = !idx[5] && idx[4:3] != 2'h0;
	assign mapped = paddr[11:9] == 3'h0 && paddr[1:0] == 2'h0 && (in_desc || idx[6:1] == 6'h38);
	assign zero_rd = !mapped || in_desc && (idx[2:0] == 3'h3 || idx[2:0] == 3'h4);
	assign q_ok = bm_query.valid && bm_query.ep != 2'h0;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// --------
	// checks
	// --------
	a_ready_wait: assert property (psel && !penable |-> !pready ##1 !pready ##1 pready)
		else $error("pready late or early");
	a_ready_pulse: assert property (pready |-> penable && $past(psel && penable) && !$past(pready))
		else $error("pready outside access");
	a_err_map: assert property (pready |-> pslverr == !mapped)
		else $error("pslverr wrong for address");
	a_err_only: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_read_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000 && (!zero_rd || prdata[7:0] == 8'h00))
		else $error("read bits not zero");
	a_view_answer: assert property (bm_view.valid == $past(q_ok))
		else $error("view valid not one cycle after query");
	a_view_pad: assert property (bm_view.valid |-> bm_view.x_addr[2:0] == 3'h0 && bm_view.y_addr[2:0] == 3'h0)
		else $error("buffer address low bits set");
	a_view_hold: assert property (!q_ok |=> $stable(bm_view[$bits(bm_view_t)-2:0]))
		else $error("view fields moved");
	a_irq_cause: assert property ($changed(irq) |-> $past(bm_done.valid || pready && pwrite, 2))
		else $error("irq moved without cause");
	c_irq: cover property ($rose(irq));
	c_err: cover property (pslverr);
	c_stall: cover property (bm_view.valid && bm_view.stall);
endmodule : endpoint_descriptor_monitor
`default_nettype wire

// file: bench/bm_model.sv
// Purpose: buffer manager stand-in on the query and done ports
// Assumes: requests last one cycle
// Notes:   idle fields carry inverted values, never stale ones
`timescale 1ns/1ns
`default_nettype none
module bm_model
	import endpoint_descriptor_pkg::*;
(
	input wire logic pclk,
	output var ep_sel_t bm_query,
	input wire bm_view_t bm_view,
	output var bm_done_t bm_done
);
	initial begin
		bm_query = '0;
		bm_done = '0;
	end
	// one-cycle query, view taken once settled
	task automatic query(input logic d, input logic [1:0] e, output bm_view_t r);
		@(posedge pclk);
		bm_query <= '{1'b1, d, e};
		@(posedge pclk);
		bm_query <= '{1'b0, ~d, ~e};
		@(negedge pclk);
		r = bm_view;
	endtask : query
	task automatic done(input logic d, input logic [1:0] e, input logic y, input logic [7:0] c,
		input logic brk);
		bm_view_t r;
		query(d, e, r);
		if (r.enabled || brk) begin
			@(posedge pclk);
			bm_done <= '{1'b1, d, e, y, c};
			@(posedge pclk);
			bm_done <= '{1'b0, ~d, ~e, ~y, ~c};
		end
	endtask : done
endmodule : bm_model
`default_nettype wire

// file: bench/usb_endpoint_descriptor_block_tb.sv
// Purpose: random and corner tests of the descriptor block
// Assumes: apb master waits on pready
// Notes:   a byte model of six descriptors gives expectations
`timescale 1ns/1ns
`default_nettype none
module usb_endpoint_descriptor_block_tb
	import endpoint_descriptor_pkg::*;
	;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd_data;
	logic pready, pslverr, irq, y;
	ep_sel_t bm_query;
	bm_view_t bm_view, v;
	bm_done_t bm_done;
	logic [7:0] mem [6][8]; // expected descriptor bytes
	logic [7:0] c;
	logic [31:0] seed = 32'h0001_82db;
	int num_errors = 0, n_compared = 0;
	always #4 pclk = ~pclk;
	endpoint_descriptor_block dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bm_query(bm_query), .bm_view(bm_view),
		.bm_done(bm_done), .irq(irq));
	bm_model bm (.pclk(pclk), .bm_query(bm_query), .bm_view(bm_view), .bm_done(bm_done));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [11:0] ad(int s, int o);
		return 12'((s < 3 ? 8 * s + 8 : 8 * s + 48) * 4 + o * 4);
	endfunction : ad
	// spares read zero, config low bits zero
	function automatic logic [7:0] ex(int s, int o);
		return (o == 3 || o == 4) ? 8'h00 : o == 0 ? mem[s][o] & 8'hfc : mem[s][o];
	endfunction : ex
	// count 0..64 with random full flag
	function automatic logic [7:0] cnt();
		logic [31:0] r;
		r = rnd();
		return {r[31], 7'(r % 65)};
	endfunction : cnt
	task automatic chk(input string n, input logic [63:0] s, input logic [63:0] x);
		n_compared++;
		if (s !== x) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, x, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= 32'(d);
		@(posedge pclk);
		penable <= 1'b1;
		// request stands until pready is sampled high at a rising edge
		do @(posedge pclk); while (pready !== 1'b1);
		rd_data = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdall(input int s);
		for (int o = 0; o < 8; o++) begin
			apb(1'b0, ad(s, o), 8'h00);
			chk("byte", 64'(rd_data), 64'(ex(s, o)));
		end
	endtask : rdall
	task end_sim;
		if (num_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim
	initial begin
		repeat (30000) @(posedge pclk);
		num_errors++;
		end_sim();
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, then random fill and readback
		for (int s = 0; s < 6; s++) begin
			mem[s] = '{default: 8'h00};
			rdall(s);
			for (int o = 0; o < 8; o++) begin
				mem[s][o] = (o == 2 || o >= 6) ? cnt() : 8'(rnd());
				if (o == 0)
					mem[s][0][6] = 1'b0;
				apb(1'b1, ad(s, o), mem[s][o]);
			end
			rdall(s);
			bm.query(s >= 3, 2'(s % 3 + 1), v);
			chk("view", 64'(v), 64'({1'b1, mem[s][0][7], mem[s][0][3], mem[s][0][4], mem[s][0][5],
				mem[s][1], 3'h0, mem[s][5], 3'h0, mem[s][2], mem[s][6], mem[s][7][6:0]}));
		end
		apb(1'b1, 12'h080, 8'hff);
		apb(1'b0, 12'h080, 8'h00);
		chk("unmapped", 64'({err, rd_data}), 64'h1_0000_0000);
		bm.query(1'b0, 2'h0, v);
		chk("ep0", 64'(v.valid), 64'h0);
		// completion per endpoint: count, toggle, irq
		apb(1'b1, 12'h1c4, 8'h3f);
		for (int s = 0; s < 6; s++) begin
			mem[s][0] = mem[s][0] | 8'h84;
			apb(1'b1, ad(s, 0), mem[s][0]);
			c = cnt();
			y = rnd() > 32'h7fff_ffff;
			bm.done(s >= 3, 2'(s % 3 + 1), y, c, 1'b0);
			mem[s][y ? 6 : 2] = c;
			mem[s][0] ^= 8'h20;
			repeat (2) @(negedge pclk);
			chk("irq", 64'(irq), 64'h1);
			apb(1'b0, 12'h1c0, 8'h00);
			chk("status", 64'(rd_data), 64'h1 << s);
			apb(1'b1, 12'h1c0, 8'(1 << s));
			repeat (2) @(negedge pclk);
			chk("irq clear", 64'(irq), 64'h0);
			rdall(s);
		end
		// disabled, no irq enable, then masked
		apb(1'b1, 12'h1c4, 8'h00);
		for (int k = 0; k < 3; k++) begin
			mem[0][0] = k == 0 ? 8'h04 : k == 1 ? 8'h80 : 8'h84;
			apb(1'b1, ad(0, 0), mem[0][0]);
			c = cnt();
			bm.done(1'b0, 2'h1, 1'b0, c, 1'b1);
			if (k > 0) begin
				mem[0][2] = c;
				mem[0][0] ^= 8'h20;
			end
			repeat (2) @(negedge pclk);
			chk("masked irq", 64'(irq), 64'h0);
			apb(1'b0, 12'h1c0, 8'h00);
			chk("status", 64'(rd_data), k == 2 ? 64'h1 : 64'h0);
			rdall(0);
		end
		apb(1'b1, 12'h1c4, 8'h01);
		repeat (2) @(negedge pclk);
		chk("unmasked irq", 64'(irq), 64'h1);
		end_sim();
	end
endmodule : usb_endpoint_descriptor_block_tb
bind endpoint_descriptor_block endpoint_descriptor_monitor mon (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .bm_query(bm_query), .bm_view(bm_view),
	.bm_done(bm_done), .irq(irq));
`default_nettype wire
